// ### rtl/bmfc_top.sv
// Burst-mode sequencing and fault response for a full-bridge converter
// Notes on behaviour
// - Burst only allowed while host power-mode setting equals zero.
// - Burst entry level comes from threshold input, LSB half the current unit.
// - Burst error threshold counts 1.25 mV steps at output sense.
// - Enter burst when load current drops below entry level.
// - Entering burst stops all switching into burst-off.
// - In burst-off, restart when output fell beyond error threshold.
// - Compensator output frozen at pre-burst value throughout burst.
// - Burst-on runs exactly the configured number of switching cycles, and one when it is set to zero.
// - Synchronous rectifier drives held off during burst mode.
// - Bridge switching emits complete positive/negative half-cycle pairs unless a shutdown masks the drives mid-pair.
// - Over-current: run 2 ms, shut down, retry once after 2 ms.
// - Over-temperature: disable, resume when below warning limit.
// - Fast over-current or short: immediate shutdown, latched until cleared.
// - Fault detectors need consecutive detections and apply hysteresis.
// - Rectified-sense input over-voltage latches shutdown until cleared.
// - With primary sense, switch to it after fault and auto-restart.
`timescale 1ns/1ps
module bmfc_top
  import bmfc_pkg::*;
#(
  parameter int OC_DLY = OC_DELAY_CYC
) (
  // Clock and reset
  input  wire logic                        mclk,
  input  wire logic                        rst_n,
  // Host configuration
  input  wire logic [7:0]                  power_mode,
  input  wire logic [bmfc_pkg::MEAS_W-1:0] burst_entry_current_threshold,
  input  wire logic [bmfc_pkg::MEAS_W-1:0] burst_error_threshold,
  input  wire logic [bmfc_pkg::CNT_W-1:0]  burst_cycle_count,
  input  wire logic [bmfc_pkg::MEAS_W-1:0] vout_target,
  input  wire logic [bmfc_pkg::DUTY_W-1:0] switch_period,
  input  wire logic [bmfc_pkg::DUTY_W-1:0] pid_duty,
  input  wire logic [bmfc_pkg::MEAS_W-1:0] oc_fault_limit,
  input  wire logic [bmfc_pkg::MEAS_W-1:0] oc_warn_limit,
  input  wire logic [bmfc_pkg::MEAS_W-1:0] fast_oc_limit,
  input  wire logic [bmfc_pkg::MEAS_W-1:0] ot_fault_limit,
  input  wire logic [bmfc_pkg::MEAS_W-1:0] ot_warn_limit,
  input  wire logic [bmfc_pkg::MEAS_W-1:0] vin_ov_limit,
  input  wire logic [bmfc_pkg::MEAS_W-1:0] fault_hysteresis,
  input  wire logic [bmfc_pkg::CNT_W-1:0]  fault_count,
  input  wire logic                        primary_input_sense_en,
  input  wire logic                        fault_clear,
  // Measurements, sampled conversion results on mclk
  input  wire logic [bmfc_pkg::MEAS_W-1:0] load_current,
  input  wire logic [bmfc_pkg::MEAS_W-1:0] output_voltage_sense_pin,
  input  wire logic [bmfc_pkg::MEAS_W-1:0] temperature,
  input  wire logic [bmfc_pkg::MEAS_W-1:0] vin_rect,
  input  wire logic [bmfc_pkg::MEAS_W-1:0] vin_primary,
  // Gate drives
  output logic                             pri_pos_drv,
  output logic                             pri_neg_drv,
  output logic                             sync_rect_switch_a,
  output logic                             sync_rect_switch_b,
  // Status
  output logic [bmfc_pkg::DUTY_W-1:0]      duty_applied,
  output logic                             burst_active,
  output logic                             output_enabled,
  output logic                             oc_warn,
  output logic                             ot_warn,
  output logic                             fault_latched,
  output logic                             primary_sense_sel
);

  import bmfc_pkg::*;

  // ----------------------------------------------------------------
  // Fault detection
  // ----------------------------------------------------------------
  logic              oc_flt;
  logic              fast_flt;
  logic              ot_flt;
  logic              vov_flt;
  logic              psel_q;
  logic [MEAS_W-1:0] vin_sel;

  // Primary path takes over only after a shutdown
  assign vin_sel = psel_q ? vin_primary : vin_rect;

  bmfc_fault_det #(.W(MEAS_W), .CW(CNT_W)) u_oc (
    .mclk(mclk), .rst_n(rst_n), .meas(load_current), .limit(oc_fault_limit),
    .hyst(fault_hysteresis), .count_req(fault_count), .fault(oc_flt));
  bmfc_fault_det #(.W(MEAS_W), .CW(CNT_W)) u_fast (
    .mclk(mclk), .rst_n(rst_n), .meas(load_current), .limit(fast_oc_limit),
    .hyst(fault_hysteresis), .count_req(fault_count), .fault(fast_flt));
  bmfc_fault_det #(.W(MEAS_W), .CW(CNT_W)) u_ot (
    .mclk(mclk), .rst_n(rst_n), .meas(temperature), .limit(ot_fault_limit),
    .hyst(fault_hysteresis), .count_req(fault_count), .fault(ot_flt));
  bmfc_fault_det #(.W(MEAS_W), .CW(CNT_W)) u_vov (
    .mclk(mclk), .rst_n(rst_n), .meas(vin_sel), .limit(vin_ov_limit),
    .hyst(fault_hysteresis), .count_req(fault_count), .fault(vov_flt));

  // ----------------------------------------------------------------
  // Burst decisions
  // ----------------------------------------------------------------
  // Entry threshold LSB is half a current unit, so compare against doubled load
  wire [MEAS_W:0] load_x2     = {load_current, 1'b0};
  wire            burst_allow = (power_mode == POWER_MODE_BURST);
  wire            light_load  = load_x2 < {1'b0, burst_entry_current_threshold};
  // Both sides are in 1.25 mV counts at the sense pin
  wire [MEAS_W:0] drop_lvl    = {1'b0, vout_target} - {1'b0, burst_error_threshold};
  wire            vout_low    = ({1'b0, output_voltage_sense_pin} < drop_lvl) &&
                                (burst_error_threshold <= vout_target);

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  bmfc_state_t        st_q;
  bmfc_state_t        st_d;
  logic [TMR_W-1:0]   tmr_q;
  logic               retried_q;
  logic [CNT_W-1:0]   reps_q;
  logic [DUTY_W-1:0]  frz_q;
  logic               latch_q;
  logic               pos_w;
  logic               neg_w;
  logic               pair_w;
  logic               idle_w;
  logic               pwm_run;
  logic               in_burst;
  logic [DUTY_W-1:0]  duty_use;
  wire                tmr_done = tmr_q >= TMR_W'(OC_DLY - 1);
  wire                reps_done = (reps_q + CNT_W'(1) >= burst_cycle_count);
  // Burst entry waits for a pair boundary so no half-cycle is cut short
  wire                pair_gap  = pair_w || idle_w;
  // Shutdown states mask the drives at once; the bridge finishes its pair unseen
  wire                shut_now  = fast_flt || (st_q == BMFC_RETRY_DLY) ||
                                  (st_q == BMFC_OFF_HOLD) || (st_q == BMFC_LATCHED);

  assign in_burst = (st_q == BMFC_BURST_OFF) || (st_q == BMFC_BURST_ON);

  always_comb begin
    st_d = st_q;
    unique case (st_q)
      BMFC_RUN: begin
        if (fast_flt) st_d = BMFC_LATCHED;
        else if (vov_flt && !primary_input_sense_en) st_d = BMFC_LATCHED;
        else if (vov_flt || ot_flt) st_d = BMFC_OFF_HOLD;
        else if (oc_flt) st_d = BMFC_OC_WAIT;
        else if (burst_allow && light_load && pair_gap) st_d = BMFC_BURST_OFF;
      end
      BMFC_BURST_OFF: begin
        if (fast_flt || vov_flt || ot_flt || !burst_allow || !light_load) st_d = BMFC_RUN;
        else if (vout_low) st_d = BMFC_BURST_ON;
      end
      BMFC_BURST_ON: begin
        if (pair_w && reps_done) st_d = BMFC_BURST_OFF;
      end
      BMFC_OC_WAIT: begin
        if (fast_flt) st_d = BMFC_LATCHED;
        else if (!oc_flt) st_d = BMFC_RUN;
        else if (tmr_done) st_d = retried_q ? BMFC_LATCHED : BMFC_RETRY_DLY;
      end
      BMFC_RETRY_DLY: begin
        if (tmr_done) st_d = BMFC_RUN;
      end
      BMFC_OFF_HOLD: begin
        if (!ot_flt && !vov_flt && !ot_warn) st_d = BMFC_RUN;
      end
      BMFC_LATCHED: begin
        if (fault_clear && !fast_flt && !vov_flt) st_d = BMFC_RUN;
      end
      default: st_d = BMFC_LATCHED;
    endcase
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      st_q      <= BMFC_RUN;
      tmr_q     <= '0;
      retried_q <= 1'b0;
      reps_q    <= '0;
    end else begin
      st_q      <= st_d;
      tmr_q     <= (st_d != st_q) ? '0 : tmr_q + TMR_W'(1);
      if (st_q == BMFC_RETRY_DLY && st_d == BMFC_RUN) retried_q <= 1'b1;
      else if (st_q == BMFC_LATCHED && st_d == BMFC_RUN) retried_q <= 1'b0;
      if (st_q != BMFC_BURST_ON) reps_q <= '0;
      else if (pair_w) reps_q <= reps_q + CNT_W'(1);
    end
  end

  // Freeze keeps the last pre-burst duty; updated only outside burst
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) frz_q <= '0;
    else if (!in_burst) frz_q <= pid_duty;
  end

  // Primary sense switch-over and latch status
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      psel_q  <= 1'b0;
      latch_q <= 1'b0;
    end else begin
      if (primary_input_sense_en && st_d == BMFC_OFF_HOLD) psel_q <= 1'b1;
      else if (st_d == BMFC_RUN) psel_q <= 1'b0;
      latch_q <= (st_d == BMFC_LATCHED);
    end
  end

  assign duty_use = in_burst ? frz_q : pid_duty;
  assign pwm_run  = ((st_q == BMFC_RUN) && (st_d != BMFC_BURST_OFF)) ||
                    (st_q == BMFC_OC_WAIT) ||
                    ((st_q == BMFC_BURST_ON) && !(pair_w && reps_done));

  bmfc_bridge_pwm #(.DW(DUTY_W)) u_pwm (
    .mclk(mclk), .rst_n(rst_n), .run(pwm_run), .period(switch_period),
    .on_time(duty_use), .pos_on(pos_w), .neg_on(neg_w), .pair_done(pair_w),
    .idle(idle_w));

  // ----------------------------------------------------------------
  // Registered outputs
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pri_pos_drv        <= 1'b0;
      pri_neg_drv        <= 1'b0;
      sync_rect_switch_a <= 1'b0;
      sync_rect_switch_b <= 1'b0;
      duty_applied       <= '0;
      burst_active       <= 1'b0;
      output_enabled     <= 1'b0;
      oc_warn            <= 1'b0;
      ot_warn            <= 1'b0;
      fault_latched      <= 1'b0;
      primary_sense_sel  <= 1'b0;
    end else begin
      // Fast fault and shutdown states kill the drive on the very next edge
      pri_pos_drv        <= pos_w && !shut_now;
      pri_neg_drv        <= neg_w && !shut_now;
      sync_rect_switch_a <= neg_w && !in_burst && !shut_now;
      sync_rect_switch_b <= pos_w && !in_burst && !shut_now;
      duty_applied       <= duty_use;
      burst_active       <= in_burst;
      output_enabled     <= !idle_w && !shut_now;
      oc_warn            <= load_current > oc_warn_limit;
      ot_warn            <= temperature > ot_warn_limit;
      fault_latched      <= latch_q;
      primary_sense_sel  <= psel_q;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  chk_burst_needs_mode: assert property (@(posedge mclk) disable iff (!rst_n)
    (st_q == BMFC_RUN && st_d == BMFC_BURST_OFF) |-> power_mode == 8'h00)
    else $error("burst entered without power mode zero");
  chk_burst_entry_load: assert property (@(posedge mclk) disable iff (!rst_n)
    (st_q == BMFC_RUN && st_d == BMFC_BURST_OFF) |-> light_load)
    else $error("burst entered at heavy load");
  chk_burst_off_quiet: assert property (@(posedge mclk) disable iff (!rst_n)
    (st_q == BMFC_BURST_OFF) [*3] |-> !pri_pos_drv && !pri_neg_drv)
    else $error("switching during burst-off");
  chk_wake_on_drop: assert property (@(posedge mclk) disable iff (!rst_n)
    (st_q == BMFC_BURST_OFF && st_d == BMFC_BURST_ON) |-> vout_low)
    else $error("burst-on without voltage drop");
  chk_duty_frozen: assert property (@(posedge mclk) disable iff (!rst_n)
    in_burst && $past(in_burst) |-> duty_use == $past(duty_use))
    else $error("duty moved in burst");
  chk_burst_reps: assert property (@(posedge mclk) disable iff (!rst_n)
    (st_q == BMFC_BURST_ON && st_d == BMFC_BURST_OFF) |->
      (reps_q + 8'h01 >= burst_cycle_count))
    else $error("burst-on ended early");
  chk_sr_off_burst: assert property (@(posedge mclk) disable iff (!rst_n)
    $past(in_burst) |-> !sync_rect_switch_a && !sync_rect_switch_b)
    else $error("rectifier on in burst");
  chk_oc_retry_once: assert property (@(posedge mclk) disable iff (!rst_n)
    (st_q == BMFC_OC_WAIT && st_d != BMFC_OC_WAIT && oc_flt && !fast_flt) |->
      (tmr_done && st_d == (retried_q ? BMFC_LATCHED : BMFC_RETRY_DLY)))
    else $error("over-current response wrong");
  chk_ot_resume: assert property (@(posedge mclk) disable iff (!rst_n)
    (st_q == BMFC_OFF_HOLD && st_d == BMFC_RUN) |-> !ot_warn && !ot_flt)
    else $error("resumed above warning");
  chk_fast_shut: assert property (@(posedge mclk) disable iff (!rst_n)
    fast_flt |=> !pri_pos_drv && !pri_neg_drv)
    else $error("drive after fast fault");
  chk_latch_hold: assert property (@(posedge mclk) disable iff (!rst_n)
    (st_q == BMFC_LATCHED && !fault_clear) |=> st_q == BMFC_LATCHED)
    else $error("latch left without clear");
  chk_latch_no_drive: assert property (@(posedge mclk) disable iff (!rst_n)
    (st_q == BMFC_LATCHED) |=> !pri_pos_drv && !pri_neg_drv && !output_enabled)
    else $error("drive while latched");
  chk_psel_follow: assert property (@(posedge mclk) disable iff (!rst_n)
    (primary_input_sense_en && st_q == BMFC_OFF_HOLD) |-> psel_q)
    else $error("primary sense not selected");
  chk_warn_flag: assert property (@(posedge mclk) disable iff (!rst_n)
    (load_current > oc_warn_limit) |=> oc_warn)
    else $error("warning flag missed");

  cov_burst_cycle: cover property (@(posedge mclk) disable iff (!rst_n)
    st_q == BMFC_BURST_ON ##1 st_q == BMFC_BURST_OFF);
  cov_oc_retry: cover property (@(posedge mclk) disable iff (!rst_n)
    st_q == BMFC_RETRY_DLY ##1 st_q == BMFC_RUN);
  cov_fast_latch: cover property (@(posedge mclk) disable iff (!rst_n)
    $rose(latch_q));
  cov_ot_resume: cover property (@(posedge mclk) disable iff (!rst_n)
    st_q == BMFC_OFF_HOLD ##1 st_q == BMFC_RUN);
  cov_burst_entry: cover property (@(posedge mclk) disable iff (!rst_n)
    st_q == BMFC_RUN ##1 st_q == BMFC_BURST_OFF);

endmodule : bmfc_top

// ### rtl/bmfc_pkg.sv
// Package of constants and types for the burst-mode and fault control block
package bmfc_pkg;

  // ----------------------------------------------------------------
  // Power-mode code that permits burst
  // ----------------------------------------------------------------
  localparam logic [7:0]  POWER_MODE_BURST = 8'h00;

  // ----------------------------------------------------------------
  // Field widths
  // ----------------------------------------------------------------
  localparam int          MEAS_W  = 12;
  localparam int          CNT_W   = 8;
  localparam int          DUTY_W  = 10;

  // ----------------------------------------------------------------
  // Reset values of configuration (default fault limits in sense counts)
  // ----------------------------------------------------------------
  localparam logic [MEAS_W-1:0] OC_FAULT_RST   = 12'h03C; // 60 A
  localparam logic [MEAS_W-1:0] OC_WARN_RST    = 12'h038; // 56 A
  localparam logic [MEAS_W-1:0] FAST_OC_RST    = 12'h041; // 65 A
  localparam logic [MEAS_W-1:0] OT_FAULT_RST   = 12'h07D; // 125 C
  localparam logic [MEAS_W-1:0] OT_WARN_RST    = 12'h05A; // 90 C

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int          CLK_HZ        = 40_000_000;
  localparam int          OC_DELAY_US   = 2000;         // 2 ms
  localparam int          OC_DELAY_CYC  = (CLK_HZ / 1_000_000) * OC_DELAY_US;
  localparam int          TMR_W         = 17;

  // ----------------------------------------------------------------
  // Controller state
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    BMFC_RUN       = 3'b000,
    BMFC_BURST_OFF = 3'b001,
    BMFC_BURST_ON  = 3'b010,
    BMFC_OC_WAIT   = 3'b011,
    BMFC_RETRY_DLY = 3'b100,
    BMFC_OFF_HOLD  = 3'b101,
    BMFC_LATCHED   = 3'b110
  } bmfc_state_t;

endpackage : bmfc_pkg

// ### rtl/bmfc_fault_det.sv
// Fault comparator with hysteresis and consecutive-count qualification
`timescale 1ns/1ps
module bmfc_fault_det #(
  parameter int W   = 12,
  parameter int CW  = 8
) (
  // Clock and reset
  input  wire logic          mclk,
  input  wire logic          rst_n,
  // Measurement and limits
  input  wire logic [W-1:0]  meas,
  input  wire logic [W-1:0]  limit,
  input  wire logic [W-1:0]  hyst,
  input  wire logic [CW-1:0] count_req,
  // Qualified result
  output logic               fault
);

  logic [CW-1:0] cnt_q;
  logic [CW-1:0] cnt_d;
  logic          fault_q;
  logic          fault_d;
  wire  [W:0]    release_lvl = {1'b0, limit} - {1'b0, hyst};
  wire           above       = meas > limit;
  wire           below_rel   = ({1'b0, meas} < release_lvl) || (hyst > limit);
  wire  [CW-1:0] need        = (count_req == '0) ? CW'(1) : count_req;

  // Count consecutive samples; zero requested counts as one
  assign cnt_d   = !above ? '0 : (cnt_q == need) ? cnt_q : cnt_q + CW'(1);
  assign fault_d = fault_q ? !below_rel : (above && (cnt_q + CW'(1) >= need));

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q   <= '0;
      fault_q <= 1'b0;
    end else begin
      cnt_q   <= cnt_d;
      fault_q <= fault_d;
    end
  end

  assign fault = fault_q;

  chk_fault_needs_above: assert property (@(posedge mclk) disable iff (!rst_n)
    $rose(fault_q) |-> $past(above)) else $error("fault rose without level");

endmodule : bmfc_fault_det

// ### rtl/bmfc_bridge_pwm.sv
// Paired half-cycle bridge pulse generator with a programmable on-time
`timescale 1ns/1ps
module bmfc_bridge_pwm #(
  parameter int DW = 10
) (
  // Clock and reset
  input  wire logic          mclk,
  input  wire logic          rst_n,
  // Control
  input  wire logic          run,
  input  wire logic [DW-1:0] period,
  input  wire logic [DW-1:0] on_time,
  // Status
  output logic               pos_on,
  output logic               neg_on,
  output logic               pair_done,
  output logic               idle
);

  logic [DW-1:0] tmr_q;
  logic          half_q;
  logic          act_q;
  wire           end_half = tmr_q >= period;
  wire           end_pair = act_q && end_half && half_q;

  // Stop is honoured only after a negative half, so halves come in pairs
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      tmr_q  <= '0;
      half_q <= 1'b0;
      act_q  <= 1'b0;
    end else if (!act_q) begin
      tmr_q  <= '0;
      half_q <= 1'b0;
      act_q  <= run;
    end else if (end_half) begin
      tmr_q  <= '0;
      half_q <= !half_q;
      act_q  <= !(half_q && !run);
    end else begin
      tmr_q  <= tmr_q + DW'(1);
    end
  end

  assign pos_on    = act_q && !half_q && (tmr_q < on_time);
  assign neg_on    = act_q && half_q && (tmr_q < on_time);
  assign pair_done = end_pair;
  assign idle      = !act_q;

  chk_pair_whole: assert property (@(posedge mclk) disable iff (!rst_n)
    $fell(act_q) |-> $past(half_q)) else $error("unpaired half-cycle");

endmodule : bmfc_bridge_pwm

// ### dv/bmfc_stage_model.sv
// Power stage model turning bridge drive pulses into an output sense value
`timescale 1ns/1ps
module bmfc_stage_model
  import bmfc_pkg::*;
#(
  parameter int TARGET = 1000
) (
  // Clock and reset
  input  wire logic                        mclk,
  input  wire logic                        rst_n,
  // Bridge drives
  input  wire logic                        pri_pos_drv,
  input  wire logic                        pri_neg_drv,
  // Sensed output
  output logic [bmfc_pkg::MEAS_W-1:0]      output_voltage_sense_pin
);
  logic [2:0] leak_q;

  // ----------------------------------------------------------------
  // Output capacitor
  // ----------------------------------------------------------------
  // Fast charge and slow leak keep burst-off gaps far longer than a burst-on
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      output_voltage_sense_pin <= 12'(TARGET);
      leak_q                   <= 3'h0;
    end else begin
      leak_q <= leak_q + 3'h1;
      if ((pri_pos_drv | pri_neg_drv) && output_voltage_sense_pin < 12'(TARGET + 40)) begin
        output_voltage_sense_pin <= output_voltage_sense_pin + 12'h002;
      end else if (leak_q == 3'h7) begin
        output_voltage_sense_pin <= output_voltage_sense_pin - 12'h001;
      end
    end
  end
endmodule : bmfc_stage_model

// ### dv/bmfc_top_bench.sv
// Self-checking bench for burst sequencing and fault response
`timescale 1ns/1ps
module bmfc_top_bench;
  import bmfc_pkg::*;
  // ----------------------------------------------------------------
  // Signals, configuration starts at the default limits
  // ----------------------------------------------------------------
  localparam int OC_DLY = 50;
  localparam int BA = 0, OE = 1, FL = 2, POS = 3;
  logic        mclk, rst_n = 1'h0, primary_input_sense_en = 1'h0, fault_clear = 1'h0;
  logic [7:0]  power_mode = 8'h01, burst_cycle_count = 8'h03, fault_count = 8'h03;
  logic [9:0]  switch_period = 10'h009, pid_duty = 10'h005, duty_applied, d0;
  logic [11:0] burst_entry_current_threshold = 12'h032, burst_error_threshold = 12'h00F;
  logic [11:0] vout_target = 12'h3E8, oc_fault_limit = OC_FAULT_RST, oc_warn_limit = OC_WARN_RST;
  logic [11:0] fast_oc_limit = FAST_OC_RST, ot_fault_limit = OT_FAULT_RST, vin_ov_limit = 12'h050;
  logic [11:0] ot_warn_limit = OT_WARN_RST, fault_hysteresis = 12'h004, load_current = 12'h01E;
  logic [11:0] temperature = 12'h019, vin_rect = 12'h030, vin_primary = 12'h030;
  logic [11:0] output_voltage_sense_pin;
  logic        pri_pos_drv, pri_neg_drv, sync_rect_switch_a, sync_rect_switch_b, burst_active;
  logic        output_enabled, oc_warn, ot_warn, fault_latched, primary_sense_sel;
  logic        pos_p = 1'h0, neg_p = 1'h0;
  logic [3:0]  st;
  int          errors = 0, tests_run = 0, cyc = 0, pos_n = 0, neg_n = 0, sr_bad = 0, n, idle;
  assign st = {pri_pos_drv, fault_latched, output_enabled, burst_active};

  bmfc_top #(.OC_DLY(OC_DLY)) bmfc_top_i (
    .mclk, .rst_n, .power_mode, .burst_entry_current_threshold, .burst_error_threshold,
    .burst_cycle_count, .vout_target, .switch_period, .pid_duty, .oc_fault_limit,
    .oc_warn_limit, .fast_oc_limit, .ot_fault_limit, .ot_warn_limit, .vin_ov_limit,
    .fault_hysteresis, .fault_count, .primary_input_sense_en, .fault_clear, .load_current,
    .output_voltage_sense_pin, .temperature, .vin_rect, .vin_primary, .pri_pos_drv,
    .pri_neg_drv, .sync_rect_switch_a, .sync_rect_switch_b, .duty_applied, .burst_active,
    .output_enabled, .oc_warn, .ot_warn, .fault_latched, .primary_sense_sel);
  bmfc_stage_model #(.TARGET(1000)) bmfc_stage_model_i (
    .mclk, .rst_n, .pri_pos_drv, .pri_neg_drv, .output_voltage_sense_pin);

  initial begin
    mclk = 1'h0;
    forever #12.5 mclk = ~mclk;
  end

  // Edge counters, rectifier watch and the hang limit
  always @(negedge mclk) begin
    cyc++;
    if (pri_pos_drv && !pos_p) pos_n++;
    if (pri_neg_drv && !neg_p) neg_n++;
    pos_p = pri_pos_drv;
    neg_p = pri_neg_drv;
    if (burst_active === 1'h1 && {sync_rect_switch_a, sync_rect_switch_b} !== 2'h0) sr_bad++;
    if (cyc == 20000) begin
      errors++;
      give_verdict();
    end
  end

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("unexpected %s: expected %0h, seen %0h", what, exp, got);
    end
  endtask : chk

  task automatic tick(input int k);
    repeat (k) @(negedge mclk);
  endtask : tick

  task automatic wait_st(input int i, input logic v, input int lim);
    n = 0;
    while (st[i] !== v && n < lim) begin
      @(negedge mclk);
      n++;
    end
    chk("status wait", 16'(v), 16'(st[i]));
  endtask : wait_st

  task automatic pulse_clear();
    fault_clear = 1'h1;
    tick(2);
    fault_clear = 1'h0;
  endtask : pulse_clear

  task automatic give_verdict();
    $display("checks %0d, mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : give_verdict

  // ----------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------
  initial begin
    tick(19);
    chk("outputs in reset", 16'h0, 16'({st, sync_rect_switch_a, sync_rect_switch_b}));
    tick(1);
    rst_n = 1'h1;
    wait_st(POS, 1'h1, 50);
    chk("switching after reset", 16'h1, 16'(pri_pos_drv));
    load_current = 12'h014;
    tick(40);
    chk("burst with mode set", 16'h0, 16'(burst_active));
    power_mode = POWER_MODE_BURST;
    load_current = 12'h019;
    tick(40);
    chk("burst at entry level", 16'h0, 16'(burst_active));
    load_current = 12'h014;
    wait_st(BA, 1'h1, 30);
    chk("burst entry", 16'h1, 16'(burst_active));
    tick(2);
    chk("drives in burst-off", 16'h0, 16'({pri_pos_drv, pri_neg_drv}));
    d0 = duty_applied;
    pid_duty = 10'h007;
    // Count 3 then 1 so a stuck or off-by-one count shows up
    for (int k = 0; k < 2; k++) begin
      burst_cycle_count = k ? 8'h01 : 8'h03;
      pos_n = 0;
      neg_n = 0;
      wait_st(POS, 1'h1, 3000);
      n = (output_voltage_sense_pin > 12'h3D3 && output_voltage_sense_pin < 12'h3DA);
      chk("restart level", 16'h1, 16'(n));
      idle = 0;
      n = 0;
      while (idle < 44 && n < 2000) begin
        @(negedge mclk);
        n++;
        idle = (pri_pos_drv | pri_neg_drv) ? 0 : idle + 1;
      end
      chk("positive halves", 16'(burst_cycle_count), 16'(pos_n));
      chk("negative halves", 16'(burst_cycle_count), 16'(neg_n));
      chk("frozen duty", 16'(d0), 16'(duty_applied));
    end
    chk("rectifier in burst", 16'h0, 16'(sr_bad));
    load_current = 12'h01E;
    wait_st(BA, 1'h0, 2000);
    tick(20);
    chk("duty after burst", 16'h007, 16'(duty_applied));
    load_current = 12'h046;
    tick(2);
    load_current = 12'h01E;
    tick(10);
    chk("short spike", 16'h0, 16'(fault_latched));
    load_current = 12'h046;
    wait_st(FL, 1'h1, 10);
    chk("fast fault delay", 16'h1, 16'(n <= 6));
    tick(2);
    chk("fast fault stop", 16'h4, 16'(st));
    load_current = 12'h01E;
    tick(200);
    chk("no restart", 16'h2, 16'({fault_latched, output_enabled}));
    pulse_clear();
    wait_st(OE, 1'h1, 20);
    load_current = 12'h039;
    tick(10);
    chk("warning only", 16'h6, 16'({oc_warn, output_enabled, fault_latched}));
    load_current = 12'h03D;
    tick(3);
    wait_st(OE, 1'h0, 200);
    chk("run time on overload", 16'h1, 16'(n >= OC_DLY - 3 && n <= OC_DLY + 6));
    wait_st(OE, 1'h1, 200);
    chk("retry delay", 16'h1, 16'(n >= OC_DLY - 1 && n <= OC_DLY + 2));
    wait_st(FL, 1'h1, 200);
    chk("single retry", 16'h1, 16'(fault_latched));
    load_current = 12'h01E;
    pulse_clear();
    wait_st(OE, 1'h1, 20);
    temperature = 12'h082;
    wait_st(OE, 1'h0, 10);
    chk("over-temperature off", 16'h2, 16'({ot_warn, output_enabled}));
    temperature = 12'h064;
    tick(30);
    chk("hold above warning", 16'h0, 16'(output_enabled));
    temperature = 12'h050;
    wait_st(OE, 1'h1, 10);
    chk("resume below warning", 16'h2, 16'({output_enabled, ot_warn}));
    vin_rect = 12'h055;
    wait_st(FL, 1'h1, 10);
    vin_rect = 12'h030;
    tick(30);
    chk("input over-voltage latch", 16'h2, 16'({fault_latched, output_enabled}));
    pulse_clear();
    wait_st(OE, 1'h1, 20);
    chk("restart after clear", 16'h1, 16'(output_enabled));
    primary_input_sense_en = 1'h1;
    vin_rect = 12'h055;
    vin_primary = 12'h055;
    wait_st(OE, 1'h0, 10);
    tick(3);
    chk("primary sense hold", 16'h1, 16'({fault_latched, output_enabled, primary_sense_sel}));
    vin_rect = 12'h030;
    vin_primary = 12'h030;
    wait_st(OE, 1'h1, 30);
    chk("primary sense resume", 16'h1, 16'(output_enabled));
    give_verdict();
  end
endmodule : bmfc_top_bench
